// ===== logic/flag_status_pkg.sv
// flag_status_pkg: register map, field positions, reset values and carrier types for
// the serial port flag and status logic.
// assumes a 32-bit classic wishbone slave with word-aligned byte addresses.
package flag_status_pkg;

  // register byte addresses
  localparam logic [7:0] flags_addr      = 8'h18;
  localparam logic [7:0] event_stat_addr = 8'h40;
  localparam logic [7:0] event_mask_addr = 8'h44;
  localparam logic [7:0] ctrl_addr       = 8'h48;
  localparam int         addr_msb        = 7;

  // flag register field positions
  localparam int cts_bit     = 0;
  localparam int busy_bit    = 3;
  localparam int rx_empty_b  = 4;
  localparam int tx_full_b   = 5;
  localparam int rx_full_b   = 6;
  localparam int tx_empty_b  = 7;
  localparam int cts_chg_bit = 9;
  localparam int rtx_stop_b  = 13;

  // reserved field 12:10 reads as its printed reset pattern
  localparam logic [31:0] flags_fixed_ones = 32'h0000_1c00;

  // reset values of loose flags
  localparam logic cts_chg_rst  = 1'b1;
  localparam logic rtx_stop_rst = 1'b0;

  // control register fields
  localparam int tx_en_bit  = 0;
  localparam int q_en_bit   = 1;
  localparam int rxq_en_bit = 2;
  localparam logic [31:0] ctrl_rst = 32'h0000_0000;
  localparam logic [31:0] ctrl_msk = 32'h0000_0007;

  // event status / mask layout
  localparam int ev_cts_chg  = 0;
  localparam int ev_rtx_stop = 1;
  localparam int ev_rtx_go   = 2;
  localparam int ev_tx_done  = 3;
  localparam int ev_width    = 4;
  localparam logic [ev_width-1:0] ev_zero = 4'h0;

  // occupancy state of the datapath queues and holding registers
  typedef struct packed {
    logic tx_q_empty;
    logic tx_q_full;
    logic rx_q_empty;
    logic rx_q_full;
    logic tx_hold_full;
    logic rx_hold_full;
  } occupancy_t;

  // transmit engine status and flow-control events
  typedef struct packed {
    logic shift_active;
    logic xoff_sent;
    logic xon_sent;
  } line_status_t;

  // wishbone request fields
  typedef struct packed {
    logic [addr_msb:0] adr;
    logic [31:0]       dat;
    logic [3:0]        sel;
    logic              we;
  } wb_req_t;

  // transmitter activity states, gray coded along idle->shift->paused
  typedef enum logic [1:0] {
    tx_idle   = 2'b00,
    tx_shift  = 2'b01,
    tx_paused = 2'b11
  } tx_state_t;

endpackage

// ===== logic/uart_flag_status_logic.sv
// uart_flag_status_logic: read-only flag register of an asynchronous serial port,
// plus an event status / mask pair and a small control register.
// assumes occupancy and line status come from logic on clk_in; cts comes from a pin.
//
// Register access over Wishbone was decided locally.
`timescale 1ns/1ns
module uart_flag_status_logic
  import flag_status_pkg::*;
(
  // clock and reset
  input  wire logic               clk_in,
  input  wire logic               sys_rst_in,
  // wishbone slave
  input  wire logic               wb_cyc_in,
  input  wire logic               wb_stb_in,
  input  wire logic               wb_we_in,
  input  wire logic [addr_msb:0]  wb_adr_in,
  input  wire logic [3:0]         wb_sel_in,
  input  wire logic [31:0]        wb_dat_in,
  output logic      [31:0]        wb_dat_out,
  output logic                    wb_ack_out,
  // line side and datapath status
  input  wire logic               cts_pin_in,
  input  wire occupancy_t         occ_in,
  input  wire line_status_t       line_in,
  // controls toward the datapath and interrupt
  output logic                    tx_enable_out,
  output logic                    queue_enable_out,
  output logic                    receive_queue_enable_out,
  output logic                    irq_out
);

  // shared read/write decode, used by all registers
  function automatic logic hit(input wb_req_t r, input logic [addr_msb:0] a, input logic wr);
    hit = (r.adr == a) && (r.we == wr);
  endfunction

  // byte-lane merge for the control register
  function automatic logic [31:0] lane_merge(input logic [31:0] old, input wb_req_t r);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (r.sel[i]) begin
        res[8*i +: 8] = r.dat[8*i +: 8];
      end
    end
    lane_merge = res;
  endfunction

  wb_req_t            req;
  logic               access;
  logic               cts_meta_ff;
  logic               cts_sync_ff;
  logic               cts_seen_ff;
  logic               cts_chg_ff;
  logic               rtx_stop_ff;
  logic [31:0]        ctrl_ff;
  logic [ev_width-1:0] ev_stat_ff;
  logic [ev_width-1:0] ev_mask_ff;
  logic [ev_width-1:0] ev_raise;
  tx_state_t          tx_st_ff;
  tx_state_t          nxt_tx_st;
  logic               busy;
  logic               flags_rd;
  logic               rx_empty;
  logic               rx_full;
  logic               tx_empty;
  logic               tx_full;
  logic [31:0]        flags_word;
  logic [31:0]        rd_word;

  assign req    = '{adr: wb_adr_in, dat: wb_dat_in, sel: wb_sel_in, we: wb_we_in};
  // single-cycle answer: take the request only when ack is low, so ack pulses once
  assign access = wb_cyc_in && wb_stb_in && !wb_ack_out;
  assign flags_rd = access && hit(req, flags_addr, 1'b0);

  assign tx_enable_out = ctrl_ff[tx_en_bit];

  // cts pin synchroniser; first stage feeds only the second
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      cts_meta_ff <= 1'b0;
      cts_sync_ff <= 1'b0;
      cts_seen_ff <= 1'b0;
    end else begin
      cts_meta_ff <= cts_pin_in;
      cts_sync_ff <= cts_meta_ff;
      cts_seen_ff <= cts_sync_ff;
    end
  end

  // flag read clears; a change in the same cycle wins so none is lost
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      cts_chg_ff <= cts_chg_rst;
    end else if (cts_sync_ff != cts_seen_ff) begin
      cts_chg_ff <= 1'b1;
    end else if (flags_rd) begin
      cts_chg_ff <= 1'b0;
    end
  end

  // xon sent clears it; xoff wins if both arrive together
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      rtx_stop_ff <= rtx_stop_rst;
    end else if (line_in.xoff_sent) begin
      rtx_stop_ff <= 1'b1;
    end else if (line_in.xon_sent) begin
      rtx_stop_ff <= 1'b0;
    end
  end

  // transmitter activity tracking
  always_comb begin
    nxt_tx_st = tx_st_ff;
    case (tx_st_ff)
      tx_idle: begin
        // queue non-empty raises busy regardless of enable
        if (!occ_in.tx_q_empty || line_in.shift_active) begin
          nxt_tx_st = tx_shift;
        end
      end
      tx_shift: begin
        // disable mid-character pauses; busy drops unless the queue is non-empty
        if (!tx_enable_out && line_in.shift_active) begin
          nxt_tx_st = tx_paused;
        // busy ends once stop bits left and nothing waits
        end else if (!line_in.shift_active && occ_in.tx_q_empty) begin
          nxt_tx_st = tx_idle;
        end
      end
      tx_paused: begin
        if (tx_enable_out) begin
          nxt_tx_st = tx_shift;
        end
      end
      default: nxt_tx_st = tx_idle;
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      tx_st_ff <= tx_idle;
    end else begin
      tx_st_ff <= nxt_tx_st;
    end
  end

  // busy while shifting or queue pending
  // queue non-empty shows busy immediately, even while paused
  assign busy = (tx_st_ff == tx_shift) || !occ_in.tx_q_empty;

  // mode selects holding register or queue
  // receive side follows its own queue enable: single character otherwise
  assign rx_empty = receive_queue_enable_out ? occ_in.rx_q_empty : !occ_in.rx_hold_full;
  assign rx_full  = receive_queue_enable_out ? occ_in.rx_q_full  : occ_in.rx_hold_full;
  assign tx_empty = queue_enable_out ? occ_in.tx_q_empty : !occ_in.tx_hold_full;
  assign tx_full  = queue_enable_out ? occ_in.tx_q_full  : occ_in.tx_hold_full;

  // flag word assembly; reserved bits fixed
  always_comb begin
    flags_word              = flags_fixed_ones;
    flags_word[cts_bit]     = cts_sync_ff;
    flags_word[busy_bit]    = busy;
    flags_word[rx_empty_b]  = rx_empty;
    flags_word[tx_full_b]   = tx_full;
    flags_word[rx_full_b]   = rx_full;
    flags_word[tx_empty_b]  = tx_empty;
    flags_word[cts_chg_bit] = cts_chg_ff;
    flags_word[rtx_stop_b]  = rtx_stop_ff;
  end

  // events that feed the sticky status register
  assign ev_raise = {busy && (nxt_tx_st == tx_idle) && (tx_st_ff == tx_shift),
                     line_in.xon_sent,
                     line_in.xoff_sent,
                     cts_sync_ff != cts_seen_ff};

  // sticky status: write one to clear, a new event wins over the clear
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      ev_stat_ff <= ev_zero;
    end else if (access && hit(req, event_stat_addr, 1'b1) && req.sel[0]) begin
      ev_stat_ff <= (ev_stat_ff & ~req.dat[ev_width-1:0]) | ev_raise;
    end else begin
      ev_stat_ff <= ev_stat_ff | ev_raise;
    end
  end

  // mask register
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      ev_mask_ff <= ev_zero;
    end else if (access && hit(req, event_mask_addr, 1'b1) && req.sel[0]) begin
      ev_mask_ff <= req.dat[ev_width-1:0];
    end
  end

  // control register steers mode selection and transmit enable
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      ctrl_ff <= ctrl_rst;
    end else if (access && hit(req, ctrl_addr, 1'b1)) begin
      ctrl_ff <= lane_merge(ctrl_ff, req) & ctrl_msk;
    end
  end

  // mode outputs registered so they come straight from flops
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      queue_enable_out         <= 1'b0;
      receive_queue_enable_out <= 1'b0;
    end else begin
      queue_enable_out         <= ctrl_ff[q_en_bit];
      receive_queue_enable_out <= ctrl_ff[rxq_en_bit];
    end
  end

  // interrupt level, one cycle behind the status bits
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= |(ev_stat_ff & ev_mask_ff);
    end
  end

  // read mux; unmapped addresses read zero and still ack
  always_comb begin
    case (req.adr)
      flags_addr:      rd_word = flags_word;
      event_stat_addr: rd_word = {{(32-ev_width){1'b0}}, ev_stat_ff};
      event_mask_addr: rd_word = {{(32-ev_width){1'b0}}, ev_mask_ff};
      ctrl_addr:       rd_word = ctrl_ff;
      default:         rd_word = 32'h0000_0000;
    endcase
  end

  // flag register has no write path; writes are acked and dropped
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      wb_ack_out <= 1'b0;
      wb_dat_out <= 32'h0000_0000;
    end else begin
      wb_ack_out <= access;
      if (access && !req.we) begin
        wb_dat_out <= rd_word;
      end
    end
  end

  // a synchronised cts edge shows up as the change flag next cycle
  a_cts_change_set: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (cts_sync_ff != cts_seen_ff) |=> cts_chg_ff)
    else $error("cts change not flagged");

  a_flag_read_clear: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (flags_rd && cts_sync_ff == cts_seen_ff) |=> !cts_chg_ff)
    else $error("cts change flag not cleared by read");

  a_busy_queue: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    !occ_in.tx_q_empty |-> busy ##1 (tx_st_ff != tx_idle))
    else $error("busy or activity missed a pending transmit queue");

  a_busy_pause: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (tx_st_ff == tx_shift && !tx_enable_out && line_in.shift_active && occ_in.tx_q_empty)
      |=> (tx_st_ff == tx_paused) && (occ_in.tx_q_empty -> !busy))
    else $error("busy not dropped on disable");

  a_busy_hold: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (tx_st_ff == tx_shift && line_in.shift_active && tx_enable_out) |=> busy)
    else $error("busy fell while shifting");

  a_rx_empty_mode: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    flags_word[rx_empty_b] == (receive_queue_enable_out ? occ_in.rx_q_empty
                                                        : !occ_in.rx_hold_full))
    else $error("receive empty wrong for mode");

  a_tx_full_mode: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    !queue_enable_out |-> flags_word[tx_full_b] == occ_in.tx_hold_full)
    else $error("transmit full wrong in character mode");

  a_rx_full_mode: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    receive_queue_enable_out |-> flags_word[rx_full_b] == occ_in.rx_q_full)
    else $error("receive full wrong in queue mode");

  a_tx_empty_mode: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    queue_enable_out |-> flags_word[tx_empty_b] == occ_in.tx_q_empty)
    else $error("transmit empty wrong in queue mode");

  a_xoff_stop: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    line_in.xoff_sent |=> flags_word[rtx_stop_b])
    else $error("remote stopped not set after xoff");

  a_xon_go: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (line_in.xon_sent && !line_in.xoff_sent) |=> !flags_word[rtx_stop_b])
    else $error("remote stopped not cleared after xon");

  a_rx_single_char: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    !receive_queue_enable_out |-> rx_full == !rx_empty)
    else $error("single character receive mode inconsistent");

  a_cts_level: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (!$past(sys_rst_in) && !$past(sys_rst_in, 2))
      |-> flags_word[cts_bit] == $past(cts_pin_in, 2))
    else $error("cts bit not the synchronised level");

  // only a flag read takes a pending change flag down
  a_cts_chg_hold: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (cts_chg_ff && !flags_rd) |=> cts_chg_ff)
    else $error("cts change flag lost without a read");

  // a cleared change flag stays clear while the level is steady
  a_cts_chg_quiet: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (!cts_chg_ff && cts_sync_ff == cts_seen_ff) |=> !cts_chg_ff)
    else $error("cts change flag set with no change");

  // re-enable while paused brings busy back to finish the character
  a_busy_resume: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (tx_st_ff == tx_paused && tx_enable_out) |=> busy)
    else $error("busy not restored on re-enable");

  // activity ends only when the shifter is done and nothing waits
  a_busy_done: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (tx_st_ff == tx_shift && !line_in.shift_active && occ_in.tx_q_empty)
      |=> (tx_st_ff == tx_idle) && (busy == !occ_in.tx_q_empty))
    else $error("busy state did not end after the last stop bit");

  // remote stopped moves only on a flow-control event
  a_rtx_hold: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    !(line_in.xoff_sent || line_in.xon_sent) |=> $stable(rtx_stop_ff))
    else $error("remote stopped changed with no flow control event");

  // a flag read returns the word that stood when it was taken
  a_read_data: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    flags_rd |=> wb_ack_out && (wb_dat_out == $past(flags_word)))
    else $error("flag read returned the wrong word");

  // queue mode reports the transmit queue itself
  a_tx_full_queue: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    queue_enable_out |-> flags_word[tx_full_b] == occ_in.tx_q_full)
    else $error("transmit full wrong in queue mode");

endmodule

// ===== verification/remote_line_model.sv
// remote_line_model: far side of the serial port and the datapath status behind it.
// assumes the bench steers it with request inputs sampled on clk_in.
`timescale 1ns/1ns
module remote_line_model
  import flag_status_pkg::*;
(
  // clock
  input  wire logic          clk_in,
  // requests from the bench
  input  wire logic          cts_req_in,
  input  wire occupancy_t    occ_req_in,
  input  wire line_status_t  line_req_in,
  // toward the flag logic
  output logic               cts_pin_out,
  output occupancy_t         occ_out,
  output line_status_t       line_out
);
  // launched one edge after the request; one driver per output, unknown only
  // until the first edge, which falls inside reset
  always @(posedge clk_in) begin
    cts_pin_out <= cts_req_in;
    occ_out     <= occ_req_in;
    line_out    <= line_req_in;
  end
endmodule

// ===== verification/uart_flag_status_logic_test.sv
// uart_flag_status_logic_test: self-checking bench for the flag register logic.
// assumes the flag logic answers wishbone one cycle after taking a request.
`timescale 1ns/1ns
module uart_flag_status_logic_test
  import flag_status_pkg::*;
;
  logic               clk_in;
  logic               sys_rst_in;
  logic               cyc, stb, we, cts_v, cts_pin, sh, xo, xn, qen, rxq, rtx, irq;
  logic [addr_msb:0]  adr;
  logic [3:0]         sel;
  logic [31:0]        dat, rdat;
  logic               ack, txe, qe, rqe;
  occupancy_t         occ_v, occ;
  line_status_t       ln;
  logic [31:0]        seed;
  logic [31:0]        exp_q[$];
  int                 fail_count, cmp_count, m;

  remote_line_model i_line (.clk_in(clk_in), .cts_req_in(cts_v), .occ_req_in(occ_v),
    .line_req_in(line_status_t'({sh, xo, xn})), .cts_pin_out(cts_pin), .occ_out(occ),
    .line_out(ln));

  uart_flag_status_logic i_dut (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .wb_cyc_in(cyc),
    .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(dat),
    .wb_dat_out(rdat), .wb_ack_out(ack), .cts_pin_in(cts_pin), .occ_in(occ),
    .line_in(ln), .tx_enable_out(txe), .queue_enable_out(qe),
    .receive_queue_enable_out(rqe), .irq_out(irq));

  // 250 MHz clock
  initial begin
    clk_in = 1'b0;
    forever #2 clk_in = ~clk_in;
  end

  task automatic test_done;
    if (exp_q.size() != 0) fail_count++;
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // expected flag word from the bench's own view of the inputs
  function automatic logic [31:0] fl(input logic b, input logic c);
    logic [31:0] f;
    f = flags_fixed_ones;
    f[cts_bit]     = cts_v;
    f[busy_bit]    = b;
    f[rx_empty_b]  = rxq ? occ_v.rx_q_empty : !occ_v.rx_hold_full;
    f[tx_full_b]   = qen ? occ_v.tx_q_full : occ_v.tx_hold_full;
    f[rx_full_b]   = rxq ? occ_v.rx_q_full : occ_v.rx_hold_full;
    f[tx_empty_b]  = qen ? occ_v.tx_q_empty : !occ_v.tx_hold_full;
    f[cts_chg_bit] = c;
    f[rtx_stop_b]  = rtx;
    return f;
  endfunction

  // classic cycle; request held until ack is sampled, read data noted in the queue
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    input logic [3:0] s, input logic [31:0] e);
    int n;
    n = 0;
    @(posedge clk_in);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    sel <= s;
    if (!w) exp_q.push_back(e);
    do begin
      @(posedge clk_in);
      n++;
    end while (ack !== 1'b1 && n < 50);
    if (n >= 50) begin
      fail_count++;
      test_done();
    end
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0, 4'hf, e);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    wb(1'b1, a, d, s, 32'h0);
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clk_in);
  endtask

  task automatic pulse(input logic o, input logic n);
    @(posedge clk_in);
    xo <= o;
    xn <= n;
    @(posedge clk_in);
    xo <= 1'b0;
    xn <= 1'b0;
  endtask

  // read data checked against the oldest note when ack shows
  always @(posedge clk_in) begin
    if (ack === 1'b1 && we === 1'b0) begin
      if (exp_q.size() == 0) chk(rdat, 32'hdead_beef);
      else chk(rdat, exp_q.pop_front());
    end
  end

  initial begin
    seed = 32'h42ce79b1;
    {cyc, stb, we, cts_v, sh, xo, xn, qen, rxq, rtx} = 10'h0;
    adr = 8'h0;
    sel = 4'h0;
    dat = 32'h0;
    occ_v = 6'h28;
    fail_count = 0;
    cmp_count = 0;
    sys_rst_in = 1'b1;
    idle(5);
    sys_rst_in <= 1'b0;
    // reset values, then the read clears the change flag
    rd(flags_addr, fl(1'b0, cts_chg_rst));
    rd(flags_addr, fl(1'b0, 1'b0));
    // writes to flags ignored; unmapped and control reads
    wr(flags_addr, 32'hffff_ffff, 4'hf);
    rd(flags_addr, fl(1'b0, 1'b0));
    rd(8'h30, 32'h0);
    wr(ctrl_addr, 32'hffff_ffff, 4'hf);
    wr(ctrl_addr, 32'h0, 4'he);
    rd(ctrl_addr, ctrl_msk);
    idle(2);
    chk({29'h0, rqe, qe, txe}, 32'h7);
    // random occupancy in every mode; the transmit queue is held empty so busy stays low
    for (m = 0; m < 4; m++) begin
      qen = m[0];
      rxq = m[1];
      wr(ctrl_addr, {29'h0, rxq, qen, 1'b0}, 4'hf);
      repeat (3) begin
        occ_v <= occupancy_t'(6'($random(seed)) | 6'h20);
        idle(4);
        rd(flags_addr, fl(1'b0, 1'b0));
      end
    end
    // change raises the event and irq; clearing drops it
    wr(event_mask_addr, 32'h1, 4'hf);
    cts_v <= 1'b1;
    idle(6);
    chk({31'h0, irq}, 32'h1);
    rd(event_stat_addr, 32'h1);
    rd(flags_addr, fl(1'b0, 1'b1));
    wr(event_stat_addr, 32'h1, 4'hf);
    idle(2);
    chk({31'h0, irq}, 32'h0);
    wr(event_mask_addr, 32'h0, 4'hf);
    cts_v <= 1'b0;
    idle(6);
    chk({31'h0, irq}, 32'h0);
    rd(flags_addr, fl(1'b0, 1'b1));
    wr(event_stat_addr, 32'hf, 4'hf);
    // remote stop flag, set wins when both arrive together
    pulse(1'b1, 1'b0);
    idle(2);
    rtx = 1'b1;
    rd(flags_addr, fl(1'b0, 1'b0));
    pulse(1'b0, 1'b1);
    idle(2);
    rtx = 1'b0;
    rd(flags_addr, fl(1'b0, 1'b0));
    pulse(1'b1, 1'b1);
    idle(2);
    rtx = 1'b1;
    rd(flags_addr, fl(1'b0, 1'b0));
    rd(event_stat_addr, 32'h6);
    // lane 0 unselected: the sticky bits must survive the clear
    wr(event_stat_addr, 32'hf, 4'he);
    rd(event_stat_addr, 32'h6);
    pulse(1'b0, 1'b1);
    rtx = 1'b0;
    wr(event_stat_addr, 32'hf, 4'hf);
    // busy follows the queue with the transmitter off
    qen = 1'b1;
    rxq = 1'b0;
    wr(ctrl_addr, 32'h2, 4'hf);
    occ_v <= 6'h08;
    idle(4);
    chk({29'h0, rqe, qe, txe}, 32'h2);
    rd(flags_addr, fl(1'b1, 1'b0));
    occ_v <= 6'h28;
    idle(4);
    rd(flags_addr, fl(1'b0, 1'b0));
    rd(event_stat_addr, 32'h8);
    // busy drops on disable mid-character and returns on re-enable
    wr(ctrl_addr, 32'h3, 4'hf);
    sh <= 1'b1;
    idle(4);
    rd(flags_addr, fl(1'b1, 1'b0));
    wr(ctrl_addr, 32'h2, 4'hf);
    idle(4);
    rd(flags_addr, fl(1'b0, 1'b0));
    wr(ctrl_addr, 32'h3, 4'hf);
    idle(4);
    rd(flags_addr, fl(1'b1, 1'b0));
    sh <= 1'b0;
    idle(4);
    rd(flags_addr, fl(1'b0, 1'b0));
    idle(4);
    test_done();
  end
endmodule
